// >>> hdl/rcb_cfg_rom.sv
`timescale 1ns/1ps
module rcb_cfg_rom
   import rcb_pkg::*;
#(
   parameter int DEPTH = 2,
   parameter int WIDTH = 8
) (
   input wire logic ref_clk,
   input wire logic wr_en,
   input wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   initial begin
      if (DEPTH < 2 || WIDTH < 8) begin
         $error("rcb_cfg_rom needs at least two bytes");
      end
   end

   logic [WIDTH-1:0] mem [DEPTH];

   // Contents start erased so an unprogrammed part reads all ones when WIDTH is 8
   initial begin
      for (int i = 0; i < DEPTH; i++) begin
         mem[i] = WIDTH'(ROM_RESET);
      end
   end

   // Registered read keeps the output path short
   always_ff @(posedge ref_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule

// >>> hdl/rcb_loader.sv
`timescale 1ns/1ps
module rcb_loader
   import rcb_pkg::*;
#(
   parameter int ROM_DEPTH = 2
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic external_access_select_n,
   input wire logic p2_bit1,
   output logic mem_req,
   output logic [ADDR_W-1:0] mem_addr,
   output logic mem_page_mode,
   input wire logic mem_ack,
   input wire logic [7:0] mem_rdata,
   output logic core_release,
   output rcb_cfg_t cfg,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata
);
   initial begin
      if (ROM_DEPTH != 2) begin
         $error("rcb_loader serves exactly two on-chip configuration slots");
      end
   end

   typedef enum logic [2:0] {
      st_start, st_ext_probe, st_ext_byte0, st_ext_byte1,
      st_int_rd0, st_int_cap0, st_int_cap1, st_done
   } rcb_state_t;

   rcb_state_t state;
   logic from_ext;
   logic page_probe;
   logic [7:0] config_byte_zero;
   logic [7:0] config_byte_one;
   logic [7:0] rom_rdata;
   logic bus_wr;
   logic [7:0] bus_addr;

   // Fetch handshake decode
   wire fetch_done = mem_req && mem_ack;
   wire in_ext = (state == st_ext_probe) || (state == st_ext_byte0) || (state == st_ext_byte1);
   wire [0:0] rom_raddr = (state == st_int_cap0) ? ROM_SLOT1 : ROM_SLOT0;
   wire load_cfg = (state == st_ext_byte1 && fetch_done) || (state == st_int_cap1);

   // Bus decode
   wire bus_take = hsel && hready && htrans[1];
   wire rom_we = bus_wr && (bus_addr == REG_ROM0 || bus_addr == REG_ROM1);
   wire [0:0] rom_waddr = (bus_addr == REG_ROM1) ? ROM_SLOT1 : ROM_SLOT0;
   wire [31:0] status_word = {29'h0, cfg.page_mode, from_ext, core_release};
   wire [31:0] next_hrdata =
      (haddr[7:0] == REG_CFG0) ? {24'h0, config_byte_zero} :
      (haddr[7:0] == REG_CFG1) ? {24'h0, config_byte_one} :
      (haddr[7:0] == REG_STATUS) ? status_word : 32'h0;

   // Field decode of the captured bytes
   // Byte zero always comes from the second fetch or slot zero; the probe byte is dropped
   wire [7:0] b0 = config_byte_zero;
   wire [7:0] b1 = (state == st_int_cap1) ? rom_rdata : mem_rdata;
   wire [1:0] sel_code = {b0[B0_SEL_HI], b0[B0_SEL_LO]};
   wire [4:0] next_abus = (sel_code == SEL_256K) ? ABUS_18 :
                          (sel_code == SEL_128K) ? ABUS_17 : ABUS_16;

   rcb_cfg_rom #(.DEPTH(ROM_DEPTH), .WIDTH(8)) u_rom (
      .ref_clk(ref_clk),
      .wr_en(rom_we),
      .wr_addr(rom_waddr),
      .wr_data(hwdata[7:0]),
      .rd_addr(rom_raddr),
      .rd_data(rom_rdata)
   );

   // Load sequencer; the pin is caught at the first edge after release
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= st_start;
         from_ext <= 1'b0;
         page_probe <= 1'b0;
         mem_req <= 1'b0;
         mem_addr <= '0;
         mem_page_mode <= 1'b0;
         config_byte_zero <= 8'h00;
      end else begin
         case (state)
            st_start: begin
               from_ext <= !external_access_select_n;
               state <= external_access_select_n ? st_int_rd0 : st_ext_probe;
            end
            st_ext_probe: begin
               if (!mem_req) begin
                  mem_req <= 1'b1;
                  mem_addr <= CFG0_ADDR;
                  mem_page_mode <= 1'b0;
               end else if (mem_ack) begin
                  mem_req <= 1'b0;
                  page_probe <= !p2_bit1;
                  state <= st_ext_byte0;
               end
            end
            st_ext_byte0: begin
               if (!mem_req) begin
                  mem_req <= 1'b1;
                  mem_addr <= CFG0_ADDR;
                  mem_page_mode <= page_probe;
               end else if (mem_ack) begin
                  mem_req <= 1'b0;
                  config_byte_zero <= mem_rdata;
                  state <= st_ext_byte1;
               end
            end
            st_ext_byte1: begin
               if (!mem_req) begin
                  mem_req <= 1'b1;
                  mem_addr <= CFG1_ADDR;
               end else if (mem_ack) begin
                  mem_req <= 1'b0;
                  state <= st_done;
               end
            end
            st_int_rd0: begin
               state <= st_int_cap0;
            end
            st_int_cap0: begin
               config_byte_zero <= rom_rdata;
               state <= st_int_cap1;
            end
            st_int_cap1: begin
               state <= st_done;
            end
            st_done: begin
               state <= st_done;
            end
            default: begin
               state <= st_start;
            end
         endcase
      end
   end

   // Decoded settings load once and then hold until reset
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg <= '0;
         config_byte_one <= 8'h00;
         core_release <= 1'b0;
      end else if (load_cfg && !core_release) begin
         config_byte_one <= b1;
         cfg.wait_a_count <= rcb_wait_count({b0[B0_WSA_HI], b0[B0_WSA_LO]});
         cfg.ale_width <= b0[B0_ALE_EXT] ? ALE_SHORT : ALE_LONG;
         cfg.addr_bus_bits <= next_abus;
         cfg.a17_on_p1_7 <= (sel_code == SEL_256K);
         cfg.a16_on_p3_7 <= (sel_code == SEL_256K) || (sel_code == SEL_128K);
         cfg.split_code_data <= (sel_code == SEL_SPLIT);
         cfg.page_mode <= !b0[B0_PAGE];
         cfg.source_mode <= b0[B0_OPCODE];
         cfg.wait_b_count <= rcb_wait_count({b1[B1_WSB_HI], b1[B1_WSB_LO]});
         cfg.push_four <= b1[B1_PUSH_WIDTH];
         cfg.code_window_map <= !b1[B1_CODE_MAP];
         core_release <= 1'b1;
      end
   end

   // Zero-wait slave; the on-chip bytes only matter at the next load
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bus_wr <= 1'b0;
         bus_addr <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0;
      end else begin
         bus_wr <= bus_take && hwrite;
         if (bus_take) begin
            bus_addr <= haddr[7:0];
         end
         if (bus_take && !hwrite) begin
            hrdata <= next_hrdata;
         end
      end
   end

   // Assertion helpers
   int unsigned beat_seen;
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         beat_seen <= 0;
      end else if (fetch_done) begin
         beat_seen <= beat_seen + 1;
      end
   end

   a_core_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
      core_release |=> core_release && $stable(cfg) && $stable(config_byte_zero))
      else $error("settings changed after load");

   a_ext_addr_top: assert property (@(posedge ref_clk) disable iff (sys_rst)
      mem_req |-> (mem_addr == CFG0_ADDR || mem_addr == CFG1_ADDR))
      else $error("fetch outside configuration array");

   a_int_no_fetch: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state != st_start && !from_ext) |-> !mem_req)
      else $error("external fetch in on-chip mode");

   a_ext_three_beats: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $rose(core_release) && from_ext |-> beat_seen == 3)
      else $error("external load did not fetch three bytes");

   a_probe_page: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state == st_ext_probe && fetch_done) ##2 (mem_req && state == st_ext_byte0)
      |-> mem_page_mode == !$past(p2_bit1, 2))
      else $error("second fetch mode does not follow probe");

   a_wait_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      core_release |-> cfg.wait_a_count ==
         WS_MAX - {config_byte_zero[B0_WSA_HI], config_byte_zero[B0_WSA_LO]})
      else $error("wait A count wrong");

   a_ale_width: assert property (@(posedge ref_clk) disable iff (sys_rst)
      core_release |-> cfg.ale_width == (config_byte_zero[B0_ALE_EXT] ? ALE_SHORT : ALE_LONG))
      else $error("latch pulse width wrong");

   a_bus_width: assert property (@(posedge ref_clk) disable iff (sys_rst)
      core_release && cfg.a17_on_p1_7 |-> cfg.addr_bus_bits == ABUS_18 && cfg.a16_on_p3_7)
      else $error("address bus width wrong");

   a_page_opcode: assert property (@(posedge ref_clk) disable iff (sys_rst)
      core_release |-> cfg.page_mode == !config_byte_zero[B0_PAGE] &&
         cfg.source_mode == config_byte_zero[B0_OPCODE])
      else $error("page or opcode mode wrong");

   a_byte_one: assert property (@(posedge ref_clk) disable iff (sys_rst)
      core_release |-> cfg.push_four == config_byte_one[B1_PUSH_WIDTH] &&
         cfg.code_window_map == !config_byte_one[B1_CODE_MAP] &&
         cfg.wait_b_count == WS_MAX - {config_byte_one[B1_WSB_HI], config_byte_one[B1_WSB_LO]})
      else $error("byte one decode wrong");

   a_bus_okay: assert property (@(posedge ref_clk) disable iff (sys_rst)
      hreadyout && !hresp)
      else $error("slave not ready or error response");

   // Fetch sequencing and decode guards
   a_cfg_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !core_release |-> cfg == '0)
      else $error("settings visible before load");

   a_pin_once: assert property (@(posedge ref_clk) disable iff (sys_rst)
      state != st_start |=> $stable(from_ext))
      else $error("source pin taken more than once");

   a_probe_mode: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state == st_ext_probe && mem_req) |-> !mem_page_mode)
      else $error("probe fetch not in non-page mode");

   a_req_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (mem_req && !mem_ack) |=> mem_req && $stable(mem_addr) && $stable(mem_page_mode))
      else $error("fetch request dropped before answer");

   a_fetch_gap: assert property (@(posedge ref_clk) disable iff (sys_rst)
      fetch_done |=> !mem_req)
      else $error("no idle cycle between fetches");

   a_sel_decode: assert property (@(posedge ref_clk) disable iff (sys_rst)
      core_release |-> cfg.a16_on_p3_7 == !config_byte_zero[B0_SEL_HI] &&
         cfg.split_code_data == (config_byte_zero[B0_SEL_HI] && config_byte_zero[B0_SEL_LO]))
      else $error("memory signal select decode wrong");

   a_narrow_bus: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (core_release && !cfg.a16_on_p3_7) |-> cfg.addr_bus_bits == ABUS_16 && !cfg.a17_on_p1_7)
      else $error("16-bit bus decode wrong");

   a_mid_bus: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (core_release && cfg.a16_on_p3_7 && !cfg.a17_on_p1_7) |-> cfg.addr_bus_bits == ABUS_17)
      else $error("17-bit bus decode wrong");

   a_int_timing: assert property (@(posedge ref_clk) disable iff (sys_rst)
      ($rose(core_release) && !from_ext) |-> $past(state) == st_int_cap1)
      else $error("on-chip load released at wrong step");
endmodule

// >>> hdl/rcb_pkg.sv
package rcb_pkg;
   // Configuration array locations in the top of memory space
   localparam int ADDR_W = 24;
   localparam logic [23:0] CFG0_ADDR = 24'hFFFFF8;
   localparam logic [23:0] CFG1_ADDR = 24'hFFFFF9;
   // On-chip configuration memory slots
   localparam logic [0:0] ROM_SLOT0 = 1'h0;
   localparam logic [0:0] ROM_SLOT1 = 1'h1;

   // Byte zero field positions
   localparam int B0_RSVD = 7;
   localparam int B0_WSA_HI = 6;
   localparam int B0_WSA_LO = 5;
   localparam int B0_ALE_EXT = 4;
   localparam int B0_SEL_HI = 3;
   localparam int B0_SEL_LO = 2;
   localparam int B0_PAGE = 1;
   localparam int B0_OPCODE = 0;
   // Byte one field positions
   localparam int B1_PUSH_WIDTH = 4;
   localparam int B1_WSB_HI = 2;
   localparam int B1_WSB_LO = 1;
   localparam int B1_CODE_MAP = 0;

   // Latch pulse widths in oscillator periods, and the largest wait-state count
   localparam logic [1:0] ALE_LONG = 2'h3;
   localparam logic [1:0] ALE_SHORT = 2'h1;
   localparam logic [1:0] WS_MAX = 2'h3;

   // Memory signal select codes
   localparam logic [1:0] SEL_256K = 2'h0;
   localparam logic [1:0] SEL_128K = 2'h1;
   localparam logic [1:0] SEL_64K = 2'h2;
   localparam logic [1:0] SEL_SPLIT = 2'h3;
   localparam logic [4:0] ABUS_18 = 5'h12;
   localparam logic [4:0] ABUS_17 = 5'h11;
   localparam logic [4:0] ABUS_16 = 5'h10;

   // Register map (byte addresses)
   localparam logic [7:0] REG_CFG0 = 8'h00;
   localparam logic [7:0] REG_CFG1 = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_ROM0 = 8'h0C;
   localparam logic [7:0] REG_ROM1 = 8'h10;
   localparam logic [7:0] ROM_RESET = 8'hFF;
   localparam int ST_DONE = 0;
   localparam int ST_EXT = 1;
   localparam int ST_PAGE = 2;

   // Decoded settings handed to the core and bus unit
   typedef struct packed {
      logic [1:0] wait_a_count;
      logic [1:0] wait_b_count;
      logic [1:0] ale_width;
      logic [4:0] addr_bus_bits;
      logic a17_on_p1_7;
      logic a16_on_p3_7;
      logic split_code_data;
      logic page_mode;
      logic source_mode;
      logic push_four;
      logic code_window_map;
   } rcb_cfg_t;

   // Active-low two-bit wait field to a wait-state count
   function automatic logic [1:0] rcb_wait_count(input logic [1:0] bits_n);
      rcb_wait_count = WS_MAX - bits_n;
   endfunction
endpackage

// >>> verification/rcb_ext_mem.sv
`timescale 1ns/1ps
// External memory holding the configuration array, with a settable answer latency
module rcb_ext_mem
   import rcb_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic mem_req,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic page_strap,
   input wire logic [7:0] byte_zero,
   input wire logic [7:0] byte_one,
   input wire logic [3:0] lat,
   output logic mem_ack,
   output logic [7:0] mem_rdata,
   output logic p2_bit1
);
   logic [3:0] cnt;
   logic [7:0] last;
   // Bytes sit at FFFFF8 and FFFFF9 (CFG0_ADDR, CFG1_ADDR); off the ack the bus shows the inverse of the last byte
   assign mem_rdata = !mem_ack ? ~last : (mem_addr == CFG1_ADDR) ? byte_one :
      (mem_addr == CFG0_ADDR) ? byte_zero : 8'hA5;
   // A page-mode board pulls port 2 bit 1 low during a fetch; otherwise the pull-up wins
   assign p2_bit1 = !(mem_req && page_strap);
   // Ack is a one-cycle pulse after lat wait cycles
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mem_ack <= 1'b0;
         cnt <= 4'h0;
         last <= 8'h00;
      end else begin
         mem_ack <= mem_req && !mem_ack && cnt == lat;
         cnt <= (mem_req && !mem_ack) ? cnt + 4'h1 : 4'h0;
         if (mem_ack) begin
            last <= mem_rdata;
         end
      end
   end
endmodule

// >>> verification/test_reset_config_byte_loader.sv
`timescale 1ns/1ps
module test_reset_config_byte_loader
   import rcb_pkg::*;
;
   logic ref_clk, sys_rst, external_access_select_n, p2_bit1, mem_req, mem_page_mode, mem_ack;
   logic core_release, page_strap, hsel, hwrite, hready, hreadyout, hresp;
   logic [ADDR_W-1:0] mem_addr;
   logic [7:0] mem_rdata, byte_zero, byte_one;
   logic [3:0] lat;
   logic [1:0] htrans, k;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   rcb_cfg_t cfg, held;
   int mismatches, n_tests;
   logic [24:0] fq[$];
   assign hready = hreadyout;

   rcb_loader #(.ROM_DEPTH(2)) i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .external_access_select_n(external_access_select_n), .p2_bit1(p2_bit1),
      .mem_req(mem_req), .mem_addr(mem_addr), .mem_page_mode(mem_page_mode),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata), .core_release(core_release), .cfg(cfg),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata));
   rcb_ext_mem i_mem (.ref_clk(ref_clk), .sys_rst(sys_rst), .mem_req(mem_req),
      .mem_addr(mem_addr), .page_strap(page_strap), .byte_zero(byte_zero),
      .byte_one(byte_one), .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .p2_bit1(p2_bit1));

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Single word transfer; read data is taken at the edge closing the data phase
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      do @(posedge ref_clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge ref_clk); while (hready !== 1'b1);
      d = hrdata;
   endtask

   // Reset for six cycles, then wait a bounded time for the core release
   task automatic load(input logic pin);
      int t;
      sys_rst <= 1'b1;
      external_access_select_n <= pin;
      fq.delete();
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t = 0;
      while (core_release !== 1'b1 && t < 200) begin
         @(posedge ref_clk);
         t++;
      end
      chk(32'(t < 200), 32'h1, "load never finished");
      @(posedge ref_clk);
   endtask

   function automatic rcb_cfg_t exp_cfg(input logic [7:0] b0, input logic [7:0] b1);
      rcb_cfg_t c;
      c.wait_a_count = 2'h3 - b0[6:5];
      c.wait_b_count = 2'h3 - b1[2:1];
      c.ale_width = b0[4] ? 2'h1 : 2'h3;
      c.addr_bus_bits = (b0[3:2] == 2'h0) ? 5'h12 : (b0[3:2] == 2'h1) ? 5'h11 : 5'h10;
      c.a17_on_p1_7 = b0[3:2] == 2'h0;
      c.a16_on_p3_7 = !b0[3];
      c.split_code_data = b0[3:2] == 2'h3;
      c.page_mode = !b0[1];
      c.source_mode = b0[0];
      c.push_four = b1[4];
      c.code_window_map = !b1[0];
      return c;
   endfunction

   // Record every completed fetch; the core must still be held while they run
   always @(posedge ref_clk) begin
      if (!sys_rst && mem_req && mem_ack) begin
         fq.push_back({mem_page_mode, mem_addr});
         chk(32'(core_release), 32'h0, "released during fetch");
      end
   end

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Whole run needs well under a thousand cycles
   initial begin
      #100000;
      mismatches++;
      $display("[FAIL] %0t watchdog expired", $time);
      summarize();
   end

   initial begin
      sys_rst = 1'b1;
      external_access_select_n = 1'b0;
      page_strap = 1'b0;
      byte_zero = 8'hFF;
      byte_one = 8'hFF;
      lat = 4'h0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      mismatches = 0;
      n_tests = 0;
      @(posedge ref_clk);
      // Every wait, select and mode code from external memory, latency varied
      for (int i = 0; i < 4; i++) begin
         k = i[1:0];
         byte_zero <= {1'b1, k, k[0], ~k, k[1], ~k[0]};
         byte_one <= {3'b111, k[0], 1'b1, ~k, k[1]};
         page_strap <= ~k[1];
         lat <= 4'(i * 2);
         load(1'b0);
         chk(32'(fq.size()), 32'h3, "fetch count");
         chk(32'(fq[0]), {7'h00, 1'b0, CFG0_ADDR}, "probe fetch");
         chk(32'(fq[1]), {7'h00, ~k[1], CFG0_ADDR}, "byte zero fetch");
         chk(32'(fq[2]), {7'h00, ~k[1], CFG1_ADDR}, "byte one fetch");
         chk(32'(cfg), 32'(exp_cfg(byte_zero, byte_one)), "decoded settings");
         ahb(1'b0, REG_STATUS, 32'h0, rd);
         chk(rd, {29'h0, ~k[1], 2'h3}, "status");
         ahb(1'b0, REG_CFG0, 32'h0, rd);
         chk(rd, {24'h0, byte_zero}, "external byte zero readback");
         ahb(1'b0, REG_CFG1, 32'h0, rd);
         chk(rd, {24'h0, byte_one}, "external byte one readback");
      end
      // Settings must not follow the pins or memory after the load
      held = cfg;
      page_strap <= ~page_strap;
      byte_zero <= 8'h80;
      repeat (20) @(posedge ref_clk);
      chk(32'(cfg), 32'(held), "settings held");
      chk(32'(core_release), 32'h1, "release held");
      // On-chip source: no external fetch at all
      ahb(1'b1, REG_ROM0, 32'h000000D6, rd);
      ahb(1'b1, REG_ROM1, 32'h000000E4, rd);
      ahb(1'b1, REG_CFG0, 32'h00000055, rd);
      load(1'b1);
      chk(32'(fq.size()), 32'h0, "external fetch with pin high");
      chk(32'(cfg), 32'(exp_cfg(8'hD6, 8'hE4)), "on-chip settings");
      ahb(1'b0, REG_STATUS, 32'h0, rd);
      chk(rd, 32'h00000001, "on-chip status");
      ahb(1'b0, REG_CFG0, 32'h0, rd);
      chk(rd, 32'h000000D6, "byte zero readback");
      ahb(1'b0, REG_CFG1, 32'h0, rd);
      chk(rd, 32'h000000E4, "byte one readback");
      ahb(1'b0, REG_ROM0, 32'h0, rd);
      chk(rd, 32'h0, "write-only slot read");
      ahb(1'b0, 8'h20, 32'h0, rd);
      chk(rd, 32'h0, "unmapped read");
      chk(32'(hresp), 32'h0, "response");
      summarize();
   end
endmodule
